/* hw/flash_read_pkg.sv */
// Types shared by the serial flash read front end
package flash_read_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h2,
    ST_DUMMY = 3'h3,
    ST_DATA = 3'h4,
    ST_IGNORE = 3'h5
  } link_state_t;

  // Number of lanes in use: 1, 2 or 4
  typedef logic [2:0] lane_count_t;

endpackage

/* hw/flash_read_regs.svh */
// Constants of the serial flash read front end: opcodes, counts, defaults
`ifndef FLASH_READ_REGS_SVH
`define FLASH_READ_REGS_SVH

// ****************************************************************
// Read opcodes
// ****************************************************************
`define OP_NORMAL_READ 8'h03
`define OP_NORMAL_READ_WIDE 8'h13
`define OP_FAST_READ 8'h0b
`define OP_FAST_READ_WIDE 8'h0c
`define OP_DUAL_LANE_READ 8'hbb
`define OP_DUAL_LANE_READ_WIDE 8'hbc
`define OP_QUAD_LANE_READ 8'heb
`define OP_UNIQUE_ID_READ 8'h4b
`define OP_INFO_ROW_READ 8'h68

// ****************************************************************
// Frame counts
// ****************************************************************
`define OPCODE_BITS 6'h08
`define ADDR_BITS_NARROW 6'h18
`define ADDR_BITS_WIDE 6'h20
`define BYTE_BITS 6'h08
`define MODE_BYTE_LAST_CYCLE 6'h03
`define CONT_READ_NIBBLE 4'ha

// ****************************************************************
// Reset values of the dummy cycle settings
// ****************************************************************
`define DUMMY_FAST_DEFAULT 5'h08
`define DUMMY_QUAD_DEFAULT 5'h06
`define DUMMY_DUAL_DEFAULT 5'h04

// ****************************************************************
// Lane enables per bus width
// ****************************************************************
`define OE_SINGLE 4'h2
`define OE_DUAL 4'h3
`define OE_QUAD 4'hf

`endif

/* hw/serial_flash_read_front_end.sv */
// Read command front end of a serial NOR flash, link side and array store
//
// Function
// - 03h reads with 3 or 4 address bytes per flag; 13h always 4.
// - Only address bits up to the valid top bit are decoded.
// - Normal read shifts bytes MSB first, address increments, wraps to zero.
// - Serial input ignored after address; frame ends when select rises.
// - Normal read during write in progress is discarded without effect.
// - Fast read 0Bh/0Ch: opcode, address, dummies in; data out on falling.
// - Fast read increments and wraps address; ignored during write in progress.
// - Four-lane mode: 2 opcode clocks, 6 or 8 address, default 6 dummies.
// - Four-lane data leaves on falling edges; address increments and wraps.
// - Four-lane fast read during write in progress is ignored.
// - Four-lane frame also serves EBh, 4Bh, 68h; the last two 3-byte only.
// - Pause low/high while clock low keeps sequence state.
// - While paused the output floats and the input is disregarded.
// - No pause with DTR, quad enable set, or pin used as reset.
// - Dual read BBh/BCh takes address two bits per edge, MSB on lane1.
// - Dual read outputs two bits per falling edge, MSB on lane1.
// - Dual read increments and wraps address; ignored during write in progress.
// - Mode byte fills first four cycles after address, inside the dummies.
// - Mode upper nibble 1010 enters continuous read; others leave it.
// - Leaving continuous read keeps the lane command mode setting.
// - Dual read during write in progress is rejected without effect.
`timescale 1ns/10ps
`default_nettype none
`include "flash_read_regs.svh"

module serial_flash_read_front_end #(
  parameter int MEM_AW = 10,
  parameter int DEV_AW = 27
) (
  // System clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Link pins
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic hold_n_in,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe_out,
  // Configuration and status levels
  input wire logic write_in_progress_in,
  input wire logic extended_address_flag_in,
  input wire logic four_lane_command_mode_in,
  input wire logic quad_enable_bit_in,
  input wire logic hold_pin_is_reset_in,
  input wire logic dtr_mode_in,
  input wire logic [4:0] dummy_fast_in,
  input wire logic [4:0] dummy_quad_in,
  input wire logic [4:0] dummy_dual_in,
  output logic frame_active_out,
  output logic continuous_read_mode_out,
  // Array load port
  input wire logic load_valid_in,
  input wire logic [MEM_AW-1:0] load_addr_in,
  input wire logic [7:0] load_data_in,
  output logic load_ready_out
);

  // ****************************************************************
  // System clock side: array, settings, status
  // ****************************************************************
  logic [7:0] mem [0:(2**MEM_AW)-1];
  logic [2:0] cs_sync_q;
  logic [2:0] cont_sync_q;
  logic busy_q;
  logic cont_stat_q;
  logic link_rst_q;
  logic cfg_wip_q;
  logic cfg_ext_q;
  logic cfg_quad_cmd_q;
  logic cfg_hold_en_q;
  logic [4:0] cfg_dummy_fast_q;
  logic [4:0] cfg_dummy_quad_q;
  logic [4:0] cfg_dummy_dual_q;
  logic cont_q;

  // Array writes only between frames, so link reads see settled data
  assign load_ready_out = ~busy_q;
  assign frame_active_out = busy_q;
  assign continuous_read_mode_out = cont_stat_q;

  always_ff @(posedge mclk_in) begin
    if (load_valid_in && !busy_q) begin
      mem[load_addr_in] <= load_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cs_sync_q <= 3'h7;
      cont_sync_q <= 3'h0;
      busy_q <= 1'b0;
      cont_stat_q <= 1'b0;
      link_rst_q <= 1'b1;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n_in};
      cont_sync_q <= {cont_sync_q[1:0], cont_q};
      link_rst_q <= 1'b0;
      if (cs_sync_q[1] == cs_sync_q[2]) begin
        busy_q <= ~cs_sync_q[2];
      end
      if (cont_sync_q[1] == cont_sync_q[2]) begin
        cont_stat_q <= cont_sync_q[2];
      end
    end
  end

  // Settings freeze while selected; the link reads them as static levels
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cfg_wip_q <= 1'b0;
      cfg_ext_q <= 1'b0;
      cfg_quad_cmd_q <= 1'b0;
      cfg_hold_en_q <= 1'b1;
      cfg_dummy_fast_q <= `DUMMY_FAST_DEFAULT;
      cfg_dummy_quad_q <= `DUMMY_QUAD_DEFAULT;
      cfg_dummy_dual_q <= `DUMMY_DUAL_DEFAULT;
    end else if (!busy_q && cs_sync_q[2]) begin
      cfg_wip_q <= write_in_progress_in;
      cfg_ext_q <= extended_address_flag_in;
      cfg_quad_cmd_q <= four_lane_command_mode_in;
      cfg_hold_en_q <= ~quad_enable_bit_in & ~hold_pin_is_reset_in &
                       ~dtr_mode_in;
      cfg_dummy_fast_q <= dummy_fast_in;
      cfg_dummy_quad_q <= dummy_quad_in;
      cfg_dummy_dual_q <= dummy_dual_in;
    end
  end

  // ****************************************************************
  // Link side: frame decode on rising serial clock
  // ****************************************************************
  flash_read_pkg::link_state_t state_q;
  flash_read_pkg::link_state_t state_d;
  flash_read_pkg::link_state_t cur_state;
  flash_read_pkg::lane_count_t lanes_q;
  flash_read_pkg::lane_count_t lanes_d;
  flash_read_pkg::lane_count_t cur_lanes;
  flash_read_pkg::lane_count_t op_lanes;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [5:0] cnt_nx;
  logic [5:0] cyc_nx;
  logic [31:0] shreg_q;
  logic [31:0] shreg_d;
  logic [31:0] shift_nx;
  logic a4_q;
  logic a4_d;
  logic cur_a4;
  logic [4:0] dummy_q;
  logic [4:0] dummy_d;
  logic [4:0] cur_dummy;
  logic dual_q;
  logic dual_d;
  logic cur_dual;
  logic [DEV_AW-1:0] rd_addr_q;
  logic [DEV_AW-1:0] rd_addr_d;
  logic cont_d;
  logic cont_a4_q;
  logic cont_a4_d;
  logic paused;
  logic [7:0] opcode;
  logic op_known;
  logic op_a4;
  logic op_dual;
  logic [4:0] op_dummy;
  logic [5:0] addr_bits;
  logic cmd_done;
  logic addr_done;
  logic mode_done;
  logic dummy_done;
  logic byte_done;
  logic [7:0] out_byte;
  logic [7:0] out_shift;
  logic [3:0] out_bits;
  logic [3:0] oe_mask;
  logic [3:0] lane_out_q;
  logic [3:0] oe_q;

  // Pause pin is sampled only while selected; host moves it with clock low
  assign paused = cfg_hold_en_q & ~hold_n_in & ~cs_n_in;

  // A new frame opens on the opcode, or on the address in continuous read
  assign cur_state = (state_q == flash_read_pkg::ST_IDLE) ?
                     (cont_q ? flash_read_pkg::ST_ADDR :
                      flash_read_pkg::ST_CMD) : state_q;
  assign cur_lanes = (state_q != flash_read_pkg::ST_IDLE) ? lanes_q :
                     cont_q ? 3'h2 : cfg_quad_cmd_q ? 3'h4 : 3'h1;
  assign cur_a4 = (state_q == flash_read_pkg::ST_IDLE) ? cont_a4_q : a4_q;
  assign cur_dummy = (state_q == flash_read_pkg::ST_IDLE) ?
                     cfg_dummy_dual_q : dummy_q;
  assign cur_dual = (state_q == flash_read_pkg::ST_IDLE) ? 1'b1 : dual_q;

  // Dual lanes put the earlier bit on lane1, quad puts it on lane3
  assign shift_nx = (cur_lanes == 3'h1) ? {shreg_q[30:0], lane_in[0]} :
                    (cur_lanes == 3'h2) ? {shreg_q[29:0], lane_in[1:0]} :
                    {shreg_q[27:0], lane_in};
  assign cnt_nx = cnt_q + {3'h0, cur_lanes};
  assign cyc_nx = cnt_q + 6'h01;
  assign opcode = shift_nx[7:0];

  // Opcode decode, single-lane and four-lane command sets
  assign op_known = cfg_quad_cmd_q ?
    (opcode == `OP_FAST_READ || opcode == `OP_FAST_READ_WIDE ||
     opcode == `OP_QUAD_LANE_READ || opcode == `OP_UNIQUE_ID_READ ||
     opcode == `OP_INFO_ROW_READ) :
    (opcode == `OP_NORMAL_READ || opcode == `OP_NORMAL_READ_WIDE ||
     opcode == `OP_FAST_READ || opcode == `OP_FAST_READ_WIDE ||
     opcode == `OP_DUAL_LANE_READ ||
     opcode == `OP_DUAL_LANE_READ_WIDE);
  assign op_a4 = (opcode == `OP_NORMAL_READ_WIDE ||
                  opcode == `OP_FAST_READ_WIDE ||
                  opcode == `OP_DUAL_LANE_READ_WIDE) ? 1'b1 :
                 (opcode == `OP_UNIQUE_ID_READ ||
                  opcode == `OP_INFO_ROW_READ) ? 1'b0 :
                 cfg_ext_q;
  assign op_dual = ~cfg_quad_cmd_q & (opcode == `OP_DUAL_LANE_READ ||
                   opcode == `OP_DUAL_LANE_READ_WIDE);
  assign op_lanes = cfg_quad_cmd_q ? 3'h4 : op_dual ? 3'h2 : 3'h1;
  assign op_dummy = cfg_quad_cmd_q ? cfg_dummy_quad_q :
                    op_dual ? cfg_dummy_dual_q :
                    (opcode == `OP_NORMAL_READ ||
                     opcode == `OP_NORMAL_READ_WIDE) ? 5'h00 :
                    cfg_dummy_fast_q;

  assign addr_bits = cur_a4 ? `ADDR_BITS_WIDE : `ADDR_BITS_NARROW;
  assign cmd_done = (cur_state == flash_read_pkg::ST_CMD) &&
                    (cnt_nx == `OPCODE_BITS);
  assign addr_done = (cur_state == flash_read_pkg::ST_ADDR) &&
                     (cnt_nx == addr_bits);
  assign mode_done = (cur_state == flash_read_pkg::ST_DUMMY) && dual_q &&
                     (cnt_q == `MODE_BYTE_LAST_CYCLE);
  assign dummy_done = (cur_state == flash_read_pkg::ST_DUMMY) &&
                      (cyc_nx == {1'b0, dummy_q});
  assign byte_done = (cur_state == flash_read_pkg::ST_DATA) &&
                     (cnt_nx == `BYTE_BITS);

  // Next-state selection for the link sequencer
  always_comb begin
    state_d = state_q;
    lanes_d = lanes_q;
    cnt_d = cnt_q;
    shreg_d = shreg_q;
    a4_d = a4_q;
    dummy_d = dummy_q;
    dual_d = dual_q;
    rd_addr_d = rd_addr_q;
    cont_d = cont_q;
    cont_a4_d = cont_a4_q;
    case (cur_state)
      flash_read_pkg::ST_CMD: begin
        shreg_d = shift_nx;
        cnt_d = cnt_nx;
        if (cmd_done) begin
          cnt_d = 6'h00;
          // Busy array or unknown opcode: sit out the frame silently
          if (!op_known || cfg_wip_q) begin
            state_d = flash_read_pkg::ST_IGNORE;
          end else begin
            state_d = flash_read_pkg::ST_ADDR;
          end
          lanes_d = op_lanes;
          a4_d = op_a4;
          dummy_d = op_dummy;
          dual_d = op_dual;
        end
      end
      flash_read_pkg::ST_ADDR: begin
        shreg_d = shift_nx;
        cnt_d = cnt_nx;
        lanes_d = cur_lanes;
        a4_d = cur_a4;
        dummy_d = cur_dummy;
        dual_d = cur_dual;
        if (state_q == flash_read_pkg::ST_IDLE && cfg_wip_q) begin
          state_d = flash_read_pkg::ST_IGNORE;
        end else if (addr_done) begin
          cnt_d = 6'h00;
          // Bits above the valid top bit are dropped
          rd_addr_d = cur_a4 ? shift_nx[DEV_AW-1:0] :
                      DEV_AW'(shift_nx[23:0]);
          state_d = (cur_dummy == 5'h00) ? flash_read_pkg::ST_DATA :
                    flash_read_pkg::ST_DUMMY;
        end
      end
      flash_read_pkg::ST_DUMMY: begin
        shreg_d = shift_nx;
        cnt_d = cyc_nx;
        if (mode_done) begin
          cont_d = (shift_nx[7:4] == `CONT_READ_NIBBLE);
          cont_a4_d = a4_q;
        end
        if (dummy_done) begin
          cnt_d = 6'h00;
          state_d = flash_read_pkg::ST_DATA;
        end
      end
      flash_read_pkg::ST_DATA: begin
        // Input lanes are not looked at once data flows
        cnt_d = cnt_nx;
        if (byte_done) begin
          cnt_d = 6'h00;
          rd_addr_d = rd_addr_q + DEV_AW'(1);
        end
      end
      flash_read_pkg::ST_IGNORE: begin
        state_d = flash_read_pkg::ST_IGNORE;
      end
      default: begin
        state_d = flash_read_pkg::ST_IGNORE;
      end
    endcase
  end

  // Select high ends every frame at once; clock need not run after
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      state_q <= flash_read_pkg::ST_IDLE;
      lanes_q <= 3'h1;
      cnt_q <= 6'h00;
      shreg_q <= 32'h0000_0000;
      a4_q <= 1'b0;
      dummy_q <= 5'h00;
      dual_q <= 1'b0;
      rd_addr_q <= '0;
    end else if (!paused) begin
      state_q <= state_d;
      lanes_q <= lanes_d;
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
      a4_q <= a4_d;
      dummy_q <= dummy_d;
      dual_q <= dual_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  // Continuous read survives frame ends; only system reset or a mode nibble other than 1010 clears it
  always_ff @(posedge sck_in or posedge link_rst_q) begin
    if (link_rst_q) begin
      cont_q <= 1'b0;
      cont_a4_q <= 1'b0;
    end else if (!paused && !cs_n_in) begin
      cont_q <= cont_d;
      cont_a4_q <= cont_a4_d;
    end
  end

  // ****************************************************************
  // Link side: data out on falling serial clock
  // ****************************************************************
  assign out_byte = mem[rd_addr_q[MEM_AW-1:0]];
  assign out_shift = out_byte << cnt_q[2:0];
  assign out_bits = (lanes_q == 3'h4) ? out_shift[7:4] :
                    (lanes_q == 3'h2) ? {2'h0, out_shift[7:6]} :
                    {2'h0, out_shift[7], 1'b0};
  assign oe_mask = (lanes_q == 3'h4) ? `OE_QUAD :
                   (lanes_q == 3'h2) ? `OE_DUAL : `OE_SINGLE;

  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lane_out_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (!paused) begin
      if (state_q == flash_read_pkg::ST_DATA) begin
        lane_out_q <= out_bits;
        oe_q <= oe_mask;
      end else begin
        lane_out_q <= 4'h0;
        oe_q <= 4'h0;
      end
    end
  end

  assign lane_out = lane_out_q;
  assign lane_oe_out = oe_q & {4{~paused}};

endmodule

`default_nettype wire

/* testbench/flash_host_model.sv */
// Host controller model driving read frames onto the flash link
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
  // Device lanes
  input wire logic [3:0] lane_out_in,
  input wire logic [3:0] lane_oe_in,
  // Link pins
  output logic sck_out,
  output logic cs_n_out,
  output logic hold_n_out,
  output wire logic [3:0] lane_wire_out,
  // Captured bytes
  output logic [7:0] rx_byte_out,
  output logic rx_tgl_out
);
  logic [3:0] drv_q;
  // Released lanes flip every clock so a stale value never reads back
  assign lane_wire_out = (lane_oe_in & lane_out_in) | (~lane_oe_in & drv_q);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    hold_n_out = 1'b1;
    drv_q = 4'h0;
    rx_byte_out = 8'h00;
    rx_tgl_out = 1'b0;
  end
  task automatic clk1();
    #40 sck_out = 1'b1;
    #40 sck_out = 1'b0;
  endtask
  task automatic sel();
    #13 cs_n_out = 1'b0;
    #40;
  endtask
  task automatic desel();
    #40 cs_n_out = 1'b1;
    #400;
  endtask
  task automatic pause(input logic lvl);
    #20 hold_n_out = lvl;
    #20;
  endtask
  // MSB first, w bits per rising edge
  task automatic put(input logic [31:0] v, input int nb, input int w);
    for (int i = nb; i > 0; i -= w) begin
      drv_q = 4'((v >> (i - w)) & ((1 << w) - 1));
      clk1();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      drv_q = ~drv_q;
      clk1();
    end
  endtask
  task automatic get(input int w, input logic keep);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      drv_q = ~drv_q;
      #40 sck_out = 1'b1;
      b = (b << w) | 8'(w == 1 ? {3'h0, lane_wire_out[1]} :
                               lane_wire_out & 4'((1 << w) - 1));
      #40 sck_out = 1'b0;
    end
    if (keep) begin
      rx_byte_out = b;
      rx_tgl_out = ~rx_tgl_out;
    end
  endtask
endmodule
`default_nettype wire

/* testbench/flash_read_asserts.sv */
// Port checks of the serial flash read front end
`timescale 1ns/10ps
`default_nettype none
module flash_read_asserts (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic hold_n_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe_out,
  // Levels
  input wire logic write_in_progress_in,
  input wire logic quad_enable_bit_in,
  input wire logic hold_pin_is_reset_in,
  input wire logic dtr_mode_in,
  input wire logic frame_active_out,
  input wire logic continuous_read_mode_out
);
  logic cs_prev_q;
  logic refused_q;
  wire logic pause_ok;
  assign pause_ok = !quad_enable_bit_in && !hold_pin_is_reset_in &&
                    !dtr_mode_in;
  // Marks a frame that began while the array was busy
  always_ff @(posedge mclk_in) begin
    cs_prev_q <= cs_n_in;
    if (srst_in || cs_n_in) begin
      refused_q <= 1'b0;
    end else if (cs_prev_q && write_in_progress_in) begin
      refused_q <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  property p_idle_float;
    cs_n_in && $past(cs_n_in) |-> lane_oe_out == 4'h0;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("lanes driven while deselected");
  property p_pause_float;
    !cs_n_in && !hold_n_in && pause_ok |-> lane_oe_out == 4'h0;
  endproperty
  a_pause_float: assert property (p_pause_float)
    else $error("lanes driven while paused");
  property p_refused_quiet;
    refused_q |-> lane_oe_out == 4'h0;
  endproperty
  a_refused_quiet: assert property (p_refused_quiet)
    else $error("busy array frame drove lanes");
  property p_refused_keep;
    refused_q |-> $stable(continuous_read_mode_out);
  endproperty
  a_refused_keep: assert property (p_refused_keep)
    else $error("busy array frame changed continuous read");
  property p_frame_sync;
    $fell(cs_n_in) |-> ##[1:5] frame_active_out;
  endproperty
  a_frame_sync: assert property (p_frame_sync)
    else $error("frame not seen after select");
  property p_oe_shape;
    lane_oe_out inside {4'h0, 4'h2, 4'h3, 4'hf};
  endproperty
  a_oe_shape: assert property (p_oe_shape)
    else $error("illegal lane enable set");
  property p_out_on_fall;
    !cs_n_in && !$past(cs_n_in) && $changed(lane_out) |-> !sck_in;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall)
    else $error("output changed outside clock low");
  property p_no_data_early;
    $fell(cs_n_in) |-> (lane_oe_out == 4'h0) [*8];
  endproperty
  a_no_data_early: assert property (p_no_data_early)
    else $error("output before opcode complete");
  c_cont: cover property ($rose(continuous_read_mode_out));
  c_pause: cover property (!cs_n_in && !hold_n_in && pause_ok);
  c_refused: cover property (refused_q);
  c_quad: cover property (lane_oe_out == 4'hf);
endmodule
bind serial_flash_read_front_end flash_read_asserts u_asserts (
  .mclk_in(mclk_in), .srst_in(srst_in), .sck_in(sck_in),
  .cs_n_in(cs_n_in), .hold_n_in(hold_n_in), .lane_out(lane_out),
  .lane_oe_out(lane_oe_out), .write_in_progress_in(write_in_progress_in),
  .quad_enable_bit_in(quad_enable_bit_in),
  .hold_pin_is_reset_in(hold_pin_is_reset_in), .dtr_mode_in(dtr_mode_in),
  .frame_active_out(frame_active_out),
  .continuous_read_mode_out(continuous_read_mode_out));
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the serial flash read front end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic write_in_progress = 1'b0;
  logic ext = 1'b0;
  logic qmode = 1'b0;
  logic [2:0] nopause = 3'h0;
  logic [4:0] dfast = 5'h08;
  logic [4:0] dquad = 5'h06;
  logic [4:0] ddual = 5'h04;
  logic load_valid = 1'b0;
  logic [3:0] load_addr = 4'h0;
  logic [7:0] load_data = 8'h00;
  logic [7:0] img [16];
  logic [7:0] qops [4] = '{8'h0b, 8'heb, 8'h4b, 8'h68};
  logic [7:0] exp_q [$];
  logic [31:0] a;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  wire logic sck, cs_n, hold_n, frame_act, cont, ready, rx_tgl;
  wire logic [3:0] lane_w, lane_o, lane_oe;
  wire logic [7:0] rx_byte;
  always #20 mclk_in = ~mclk_in;
  flash_host_model host (.lane_out_in(lane_o), .lane_oe_in(lane_oe),
    .sck_out(sck), .cs_n_out(cs_n), .hold_n_out(hold_n),
    .lane_wire_out(lane_w), .rx_byte_out(rx_byte), .rx_tgl_out(rx_tgl));
  serial_flash_read_front_end #(.MEM_AW(4)) dut (
    .mclk_in(mclk_in), .srst_in(srst_in), .sck_in(sck), .cs_n_in(cs_n),
    .hold_n_in(hold_n), .lane_in(lane_w), .lane_out(lane_o),
    .lane_oe_out(lane_oe), .write_in_progress_in(write_in_progress),
    .extended_address_flag_in(ext), .four_lane_command_mode_in(qmode),
    .quad_enable_bit_in(nopause[0]), .hold_pin_is_reset_in(nopause[1]),
    .dtr_mode_in(nopause[2]), .dummy_fast_in(dfast),
    .dummy_quad_in(dquad), .dummy_dual_in(ddual),
    .frame_active_out(frame_act), .continuous_read_mode_out(cont),
    .load_valid_in(load_valid), .load_addr_in(load_addr),
    .load_data_in(load_data), .load_ready_out(ready));
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  always @(rx_tgl) if ($time > 0) chk(rx_byte, exp_q.pop_front());
  task automatic cfg(input logic w, e, q, input logic [2:0] np);
    @(posedge mclk_in);
    write_in_progress <= w;
    ext <= e;
    qmode <= q;
    nopause <= np;
    repeat (6) @(posedge mclk_in);
  endtask
  task automatic rd(input logic [7:0] op, input int ow, input logic [31:0] ad,
                    input int nab, w, nd, md, n, input logic keep);
    host.sel();
    if (ow > 0) host.put({24'h0, op}, 8, ow);
    host.put(ad, nab, w);
    if (md >= 0) begin
      host.put(32'(md >> 4), 4, 2);
      host.idle(nd - 2);
    end else host.idle(nd);
    for (int k = 0; k < n; k++) begin
      if (keep) exp_q.push_back(img[4'(ad[3:0] + k)]);
      host.get(w, keep);
    end
    host.desel();
  endtask
  // Pause mid address and mid data; np set means the pin is not a pause
  task automatic pz(input logic [2:0] np);
    cfg(1'b0, 1'b0, 1'b0, np);
    host.sel();
    host.put(8'h0b, 8, 1);
    host.put(a >> 12, 12, 1);
    host.pause(1'b0);
    if (np == 3'h0) host.idle(3);
    host.pause(1'b1);
    host.put(a, 12, 1);
    host.idle(dfast);
    exp_q.push_back(img[a[3:0]]);
    host.get(1, 1'b1);
    host.pause(1'b0);
    chk({4'h0, lane_oe}, (np == 3'h0) ? 8'h00 : 8'h02);
    chk({6'h0, frame_act, ready}, 8'h02);
    host.pause(1'b1);
    exp_q.push_back(img[4'(a[3:0] + 1)]);
    host.get(1, 1'b1);
    host.desel();
  endtask
  initial begin
    void'($urandom(31947));
    for (int i = 0; i < 16; i++) img[i] = 8'($urandom());
    a = $urandom();
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    for (int i = 0; i < 16; i++) begin
      load_valid <= 1'b1;
      load_addr <= 4'(i);
      load_data <= img[i];
      @(posedge mclk_in);
    end
    load_valid <= 1'b0;
    a[3:0] = 4'he;
    rd(8'h03, 1, a, 24, 1, 0, -1, 3, 1'b1);
    rd(8'h13, 1, a | 32'hf8000001, 32, 1, 0, -1, 2, 1'b1);
    rd(8'h0b, 1, a, 24, 1, 8, -1, 3, 1'b1);
    @(posedge mclk_in);
    dfast <= 5'h0a;
    cfg(1'b0, 1'b1, 1'b0, 3'h0);
    rd(8'h0c, 1, a, 32, 1, 10, -1, 2, 1'b1);
    rd(8'h03, 1, a, 32, 1, 0, -1, 2, 1'b1);
    cfg(1'b0, 1'b0, 1'b1, 3'h0);
    for (int i = 0; i < 4; i++) begin
      rd(qops[i], 4, a, 24, 4, dquad, -1, 3, 1'b1);
    end
    @(posedge mclk_in);
    dquad <= 5'(7 + $urandom_range(2));
    cfg(1'b0, 1'b0, 1'b1, 3'h0);
    rd(8'h0c, 4, a, 32, 4, dquad, -1, 2, 1'b1);
    cfg(1'b0, 1'b0, 1'b0, 3'h0);
    rd(8'hbb, 1, a, 24, 2, ddual, 'h5f, 3, 1'b1);
    @(posedge mclk_in);
    ddual <= 5'(5 + $urandom_range(2));
    cfg(1'b0, 1'b0, 1'b0, 3'h0);
    rd(8'hbc, 1, a, 32, 2, ddual, 'ha3, 2, 1'b1);
    chk({7'h0, cont}, 8'h01);
    rd(8'h00, 0, a + 5, 32, 2, ddual, 'h0c, 2, 1'b1);
    chk({7'h0, cont}, 8'h00);
    rd(8'h03, 1, a + 3, 24, 1, 0, -1, 1, 1'b1);
    cfg(1'b1, 1'b0, 1'b1, 3'h0);
    rd(8'h0b, 4, a, 24, 4, 6, -1, 1, 1'b0);
    cfg(1'b1, 1'b0, 1'b0, 3'h0);
    rd(8'h03, 1, a, 24, 1, 0, -1, 1, 1'b0);
    rd(8'hbb, 1, a, 24, 2, ddual, 'ha0, 1, 1'b0);
    chk({7'h0, cont}, 8'h00);
    pz(3'h0);
    for (int i = 0; i < 3; i++) pz(3'(1 << i));
    stop_test();
  end
endmodule
`default_nettype wire
